/* File: bxo_pkg.sv */
// Shared constants, enumerations and carriers of the bit and transfer core.
// Assumes one clock domain and an AXI4-Lite master for software access.
package bxo_pkg;

  // ****************************************************************
  // Register map, byte offsets
  // ****************************************************************
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] OPND_OFF = 8'h04;
  localparam logic [7:0] STAT_OFF = 8'h08;
  localparam logic [7:0] FLAGS_OFF = 8'h0C;
  localparam logic [7:0] SP_OFF = 8'h10;
  localparam logic [7:0] RF_OFF = 8'h80;

  // Command word fields, and the busy bit of the status word
  localparam int OP_LSB = 0;
  localparam int RD_LSB = 5;
  localparam int RR_LSB = 10;
  localparam int BIT_LSB = 15;
  localparam int PTR_LSB = 18;
  localparam int MODE_LSB = 20;
  localparam int BUSY_BIT = 8;

  // Flag positions in status_flags_reg
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;

  // Reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [15:0] SP_RST = 16'h00FF;

  // Cycles per instruction class
  localparam logic [1:0] CYC_SINGLE = 2'h1;
  localparam logic [1:0] CYC_DATA = 2'h2;
  localparam logic [1:0] CYC_CODE = 2'h3;

  // Low register of the X pointer pair
  localparam logic [4:0] PTR_BASE = 5'h1A;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Enumerations
  // ****************************************************************
  typedef enum logic [4:0] {
    op_nop, rotate_right_carry_instr, arith_shift_right_instr,
    nibble_exchange_instr, bit_to_transfer_flag_instr,
    transfer_flag_to_bit_instr, overflow_flag_set_instr,
    overflow_flag_clear_instr, half_carry_set_instr,
    half_carry_clear_instr, sign_flag_set_instr, sign_flag_clear_instr,
    register_pair_copy_instr, indirect_load_instr, offset_load_instr,
    direct_load_instr, indirect_store_instr, offset_store_instr,
    direct_store_instr, code_memory_read_instr, stack_put_instr,
    stack_take_instr, sleep_instr, watchdog_restart_instr, debug_break_instr
  } bxo_op_t;

  typedef enum logic [1:0] {ptr_x, ptr_y, ptr_z, ptr_none} bxo_ptr_t;
  typedef enum logic [1:0] {mode_plain, mode_post_inc, mode_pre_dec, mode_none} bxo_mode_t;
  typedef enum logic {ph_idle, ph_run} bxo_phase_t;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } bxo_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bxo_axil_rsp_t;

  typedef struct packed {
    logic en;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } bxo_dmem_req_t;

  typedef struct packed {
    logic en;
    logic [15:0] addr;
  } bxo_pmem_req_t;

endpackage : bxo_pkg

/* File: bxo_core.sv */
// Bit, shift and data transfer execution core with an AXI4-Lite command port.
// Assumes a data SRAM with one cycle read latency and a program memory
// with two cycles read latency, both on aclk.
//
// Operation
// (RL1) Rotate right through carry, flags, one cycle
// (RL2) Bit to transfer flag, only that flag
// (RL3) Transfer flag into register bit, flags kept
// (RL4) Set or clear overflow flag alone
// (RL5) Set or clear half carry flag alone
// (RL6) Set or clear sign flag alone
// (RL7) Load then pointer plus one, two cycles
// (RL8) Pointer minus one then load, two cycles
// (RL9) Load from pointer plus offset, two cycles
// (RL10) Load from constant address, two cycles
// (RL11) Store then pointer plus one, two cycles
// (RL12) Pointer minus one then store, two cycles
// (RL13) Store to pointer plus offset, two cycles
// (RL14) Store to constant address, two cycles
// (RL15) Code memory byte at Z, three cycles
// (RL16) Push register onto stack, two cycles
// (RL17) Pop stack top into register, two cycles
// (RL18) Debug break acts only under debugging
// (RL19) Sleep issues in one cycle, requests sleep
// (RL20) Watchdog restart in one cycle
// (RL21) Arithmetic shift right keeps bit seven
// (RL22) Swap register nibbles, one cycle
// (RL23) Copy even register pair, one cycle
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
module bxo_core import bxo_pkg::*; #(
  parameter logic [15:0] SP_RESET = SP_RST,
  parameter int DISP_W = 6
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire bxo_axil_req_t axi_req,
  output bxo_axil_rsp_t axi_rsp,
  output bxo_dmem_req_t dmem,
  input wire logic [7:0] dmem_rdata,
  output bxo_pmem_req_t pmem,
  input wire logic [7:0] pmem_rdata,
  input wire logic dbg_enable,
  output logic sleep_req,
  output logic wdt_restart,
  output logic dbg_break
);

  // ****************************************************************
  // Checks and constants
  // ****************************************************************
  if (DISP_W < 1 || DISP_W > 16) begin : g_bad_disp
    $error("DISP_W must lie in 1..16");
  end

  localparam logic [15:0] DISP_MASK = 16'((17'h1 << DISP_W) - 17'h1);
  localparam logic [7:0] T_MASK = 8'(1 << FLAG_T);
  localparam logic [7:0] V_MASK = 8'(1 << FLAG_V);
  localparam logic [7:0] H_MASK = 8'(1 << FLAG_H);
  localparam logic [7:0] S_MASK = 8'(1 << FLAG_S);

  typedef struct packed {
    bxo_phase_t ph;
    logic [1:0] cnt;
    bxo_op_t op;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [2:0] bsel;
    bxo_ptr_t ptr;
    bxo_mode_t mode;
    logic [15:0] opnd;
    logic [15:0] maddr;
    logic [7:0] wbyte;
    logic [7:0] status_flags_reg;
    logic [15:0] sp;
    logic [31:0][7:0] rf;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic sleep_p;
    logic wdog_p;
    logic brk_p;
  } bxo_state_t;

  bxo_state_t q;
  bxo_state_t d;

  logic busy;
  logic retire;
  logic go;
  logic wr_go;
  bxo_op_t cmd_op;
  logic [4:0] cmd_rd;
  logic [4:0] cmd_rr;
  bxo_ptr_t cmd_ptr;
  bxo_mode_t cmd_mode;
  logic [7:0] rd_val;
  logic [7:0] rr_val;
  logic [7:0] cmd_src;
  logic [7:0] rot_exp;
  logic [7:0] tbit_exp;
  logic [15:0] ptr_now;
  logic data_op;
  logic store_op;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Pointer pairs sit in r26..r31, low byte first
  function automatic logic [4:0] ptr_idx(input bxo_ptr_t p);
    return PTR_BASE + {2'b00, p, 1'b0};
  endfunction : ptr_idx

  function automatic logic [15:0] ptr_of(input logic [31:0][7:0] rf, input bxo_ptr_t p);
    logic [4:0] i;
    i = ptr_idx(p);
    return {rf[i + 5'h01], rf[i]};
  endfunction : ptr_of

  // Byte lanes not strobed keep their old value; only the low two lanes hold state
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    return {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
  endfunction : merge

  // Command fields straight off the write data bus
  assign cmd_op = bxo_op_t'(axi_req.wdata[OP_LSB +: 5]);
  assign cmd_rd = axi_req.wdata[RD_LSB +: 5];
  assign cmd_rr = axi_req.wdata[RR_LSB +: 5];
  assign cmd_ptr = bxo_ptr_t'(axi_req.wdata[PTR_LSB +: 2]);
  assign cmd_mode = bxo_mode_t'(axi_req.wdata[MODE_LSB +: 2]);
  assign cmd_src = q.rf[cmd_rr];
  assign rd_val = q.rf[q.rd];
  assign rr_val = q.rf[q.rr];
  assign rot_exp = {q.status_flags_reg[FLAG_C], rd_val[7:1]};
  assign ptr_now = ptr_of(q.rf, q.ptr);
  assign busy = (q.ph == ph_run);
  assign retire = busy && (q.cnt == 2'h0);
  assign wr_go = axi_req.awvalid && axi_req.wvalid && !q.bvalid;

  always_comb begin
    tbit_exp = rd_val;
    tbit_exp[q.bsel] = q.status_flags_reg[FLAG_T];
  end

  // Data memory class of the latched instruction
  assign store_op = q.op inside {indirect_store_instr, offset_store_instr, direct_store_instr,
                                 stack_put_instr};
  assign data_op = store_op || (q.op inside {indirect_load_instr, offset_load_instr,
                                             direct_load_instr, stack_take_instr});

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Bus writes and reads, command issue and instruction retirement
  always_comb begin
    logic [15:0] pv;
    logic [15:0] np;
    logic [7:0] res;
    logic [7:0] a;
    logic [4:0] pi;
    logic [4:0] dp;
    logic [4:0] sp2;
    d = q;
    pv = 16'h0000;
    np = 16'h0000;
    res = 8'h00;
    a = axi_req.awaddr[7:0];
    pi = ptr_idx(q.ptr);
    dp = {q.rd[4:1], 1'b0};
    sp2 = {q.rr[4:1], 1'b0};
    go = 1'b0;
    d.sleep_p = 1'b0;
    d.wdog_p = 1'b0;
    d.brk_p = 1'b0;
    if (q.bvalid && axi_req.bready) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && axi_req.rready) begin
      d.rvalid = 1'b0;
    end
    // Writes: only the operand register may change while an instruction runs
    if (wr_go) begin
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      if (axi_req.awaddr[31:8] != 24'h000000 || a[1:0] != 2'b00) begin
        d.bresp = RESP_SLVERR;
      end else if (busy && a != OPND_OFF) begin
        d.bresp = RESP_SLVERR;
      end else if (a[7]) begin
        d.rf[a[6:2]] = 8'(merge({8'h00, q.rf[a[6:2]]}, axi_req.wdata, axi_req.wstrb));
      end else begin
        case (a)
          CTRL_OFF: go = 1'b1;
          OPND_OFF: d.opnd = merge(q.opnd, axi_req.wdata, axi_req.wstrb);
          FLAGS_OFF: d.status_flags_reg = 8'(merge({8'h00, q.status_flags_reg}, axi_req.wdata, axi_req.wstrb));
          SP_OFF: d.sp = merge(q.sp, axi_req.wdata, axi_req.wstrb);
          default: d.bresp = RESP_SLVERR;
        endcase
      end
    end
    // Reads answer one cycle after the address is taken
    if (axi_req.arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      d.rdata = 32'h00000000;
      if (axi_req.araddr[31:8] != 24'h000000 || axi_req.araddr[1:0] != 2'b00) begin
        d.rresp = RESP_SLVERR;
      end else if (axi_req.araddr[7]) begin
        d.rdata[7:0] = q.rf[axi_req.araddr[6:2]];
      end else begin
        case (axi_req.araddr[7:0])
          CTRL_OFF: d.rdata = 32'h00000000;
          OPND_OFF: d.rdata[15:0] = q.opnd;
          STAT_OFF: d.rdata = {23'h0, busy, q.status_flags_reg};
          FLAGS_OFF: d.rdata[7:0] = q.status_flags_reg;
          SP_OFF: d.rdata[15:0] = q.sp;
          default: d.rresp = RESP_SLVERR;
        endcase
      end
    end
    // Issue: latch fields and work out the memory address up front
    if (go) begin
      d.ph = ph_run;
      d.op = cmd_op;
      d.rd = cmd_rd;
      d.rr = cmd_rr;
      d.bsel = axi_req.wdata[BIT_LSB +: 3];
      d.ptr = cmd_ptr;
      d.mode = cmd_mode;
      d.wbyte = cmd_src;
      d.cnt = CYC_DATA - 2'h1;
      pv = ptr_of(q.rf, cmd_ptr);
      case (cmd_op)
        indirect_load_instr, indirect_store_instr: begin
          d.maddr = (cmd_mode == mode_pre_dec) ? pv - 16'h0001 : pv; // RL8 RL12
        end
        offset_load_instr, offset_store_instr: d.maddr = pv + (q.opnd & DISP_MASK); // RL9 RL13
        direct_load_instr, direct_store_instr: d.maddr = q.opnd; // RL10 RL14
        stack_put_instr: d.maddr = q.sp; // RL16
        stack_take_instr: d.maddr = q.sp + 16'h0001; // RL17
        code_memory_read_instr: begin
          d.ptr = ptr_z;
          d.maddr = ptr_of(q.rf, ptr_z); // RL15
          d.cnt = CYC_CODE - 2'h1;
        end
        default: d.cnt = CYC_SINGLE - 2'h1;
      endcase
    end
    // Run phase: count down, then retire on the last cycle
    if (busy && q.cnt != 2'h0) begin
      d.cnt = q.cnt - 2'h1;
    end
    if (retire) begin
      d.ph = ph_idle;
      case (q.op)
        rotate_right_carry_instr, arith_shift_right_instr: begin
          // Only bit 7 differs between rotate and arithmetic shift
          res = (q.op == arith_shift_right_instr) ? {rd_val[7], rd_val[7:1]} : rot_exp;
          d.rf[q.rd] = res; // RL1 RL21
          d.status_flags_reg[FLAG_C] = rd_val[0];
          d.status_flags_reg[FLAG_Z] = (res == 8'h00);
          d.status_flags_reg[FLAG_N] = res[7];
          d.status_flags_reg[FLAG_V] = res[7] ^ rd_val[0];
        end
        nibble_exchange_instr: d.rf[q.rd] = {rd_val[3:0], rd_val[7:4]}; // RL22
        bit_to_transfer_flag_instr: d.status_flags_reg[FLAG_T] = rr_val[q.bsel]; // RL2
        transfer_flag_to_bit_instr: d.rf[q.rd] = tbit_exp; // RL3
        overflow_flag_set_instr: d.status_flags_reg[FLAG_V] = 1'b1; // RL4
        overflow_flag_clear_instr: d.status_flags_reg[FLAG_V] = 1'b0; // RL4
        half_carry_set_instr: d.status_flags_reg[FLAG_H] = 1'b1; // RL5
        half_carry_clear_instr: d.status_flags_reg[FLAG_H] = 1'b0; // RL5
        sign_flag_set_instr: d.status_flags_reg[FLAG_S] = 1'b1; // RL6
        sign_flag_clear_instr: d.status_flags_reg[FLAG_S] = 1'b0; // RL6
        register_pair_copy_instr: begin
          d.rf[dp] = q.rf[sp2]; // RL23
          d.rf[dp + 5'h01] = q.rf[sp2 + 5'h01];
        end
        indirect_load_instr, offset_load_instr, direct_load_instr: begin
          d.rf[q.rd] = dmem_rdata; // RL7 RL9 RL10
        end
        stack_take_instr: begin
          d.rf[q.rd] = dmem_rdata; // RL17
          d.sp = q.maddr;
        end
        stack_put_instr: d.sp = q.sp - 16'h0001; // RL16
        code_memory_read_instr: d.rf[q.rd] = pmem_rdata; // RL15
        sleep_instr: d.sleep_p = 1'b1; // RL19
        watchdog_restart_instr: d.wdog_p = 1'b1; // RL20
        debug_break_instr: d.brk_p = dbg_enable; // RL18
        default: begin
        end
      endcase
      // Pointer write-back wins over a load into the same register
      if ((q.op == indirect_load_instr || q.op == indirect_store_instr ||
           q.op == code_memory_read_instr) && q.mode != mode_plain) begin
        np = (q.mode == mode_post_inc) ? q.maddr + 16'h0001 : q.maddr; // RL7 RL11 RL15
        if (q.mode == mode_post_inc || q.op != code_memory_read_instr) begin
          d.rf[pi] = np[7:0];
          d.rf[pi + 5'h01] = np[15:8];
        end
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.status_flags_reg <= FLAGS_RST;
      q.sp <= SP_RESET;
    end else begin
      q <= d;
    end
  end

  // Memory requests go out in the first run cycle only
  always_comb begin
    dmem.en = busy && data_op && (q.cnt == CYC_DATA - 2'h1);
    dmem.we = busy && store_op && (q.cnt == CYC_DATA - 2'h1); // RL11 RL14
    dmem.addr = q.maddr;
    dmem.wdata = q.wbyte;
    pmem.en = busy && (q.op == code_memory_read_instr) && (q.cnt == CYC_CODE - 2'h1);
    pmem.addr = q.maddr;
  end

  always_comb begin
    axi_rsp.awready = wr_go;
    axi_rsp.wready = wr_go;
    axi_rsp.bvalid = q.bvalid;
    axi_rsp.bresp = q.bresp;
    axi_rsp.arready = !q.rvalid;
    axi_rsp.rvalid = q.rvalid;
    axi_rsp.rdata = q.rdata;
    axi_rsp.rresp = q.rresp;
  end

  assign sleep_req = q.sleep_p;
  assign wdt_restart = q.wdog_p;
  assign dbg_break = q.brk_p;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_rotate_result: assert property (@(posedge aclk) disable iff (!aresetn) // RL1
    retire && q.op == rotate_right_carry_instr |=>
      q.rf[$past(q.rd)] == {$past(q.status_flags_reg[FLAG_C]), $past(rd_val[7:1])} &&
      q.status_flags_reg[FLAG_C] == $past(rd_val[0]))
    else $error("rotate result or carry wrong");
  a_rotate_timing: assert property (@(posedge aclk) disable iff (!aresetn) // RL1
    go && cmd_op == rotate_right_carry_instr |=> busy ##1 !busy)
    else $error("rotate not one cycle");
  a_tflag_store: assert property (@(posedge aclk) disable iff (!aresetn) // RL2
    retire && q.op == bit_to_transfer_flag_instr |=>
      q.status_flags_reg[FLAG_T] == $past(rr_val[q.bsel]) && (q.status_flags_reg | T_MASK) == ($past(q.status_flags_reg) | T_MASK))
    else $error("transfer flag store wrong");
  a_tflag_load: assert property (@(posedge aclk) disable iff (!aresetn) // RL3
    retire && q.op == transfer_flag_to_bit_instr |=>
      q.status_flags_reg == $past(q.status_flags_reg) && q.rf[$past(q.rd)][$past(q.bsel)] == $past(q.status_flags_reg[FLAG_T]))
    else $error("transfer flag load wrong");
  a_overflow_set: assert property (@(posedge aclk) disable iff (!aresetn) // RL4
    go && cmd_op == overflow_flag_set_instr |=> ##1 q.status_flags_reg == ($past(q.status_flags_reg, 2) | V_MASK))
    else $error("overflow set touched other flags");
  a_half_clear: assert property (@(posedge aclk) disable iff (!aresetn) // RL5
    go && cmd_op == half_carry_clear_instr |=> ##1 q.status_flags_reg == ($past(q.status_flags_reg, 2) & ~H_MASK))
    else $error("half carry clear wrong");
  a_sign_set: assert property (@(posedge aclk) disable iff (!aresetn) // RL6
    go && cmd_op == sign_flag_set_instr |=> ##1 q.status_flags_reg == ($past(q.status_flags_reg, 2) | S_MASK))
    else $error("sign set wrong");
  a_post_inc: assert property (@(posedge aclk) disable iff (!aresetn) // RL7
    retire && q.op == indirect_load_instr && q.mode == mode_post_inc |=>
      ptr_now == $past(q.maddr) + 16'h0001)
    else $error("pointer not incremented");
  a_load_timing: assert property (@(posedge aclk) disable iff (!aresetn) // RL10
    go && cmd_op == direct_load_instr |=> dmem.en && !dmem.we ##1 busy && !dmem.en ##1 !busy)
    else $error("direct load not two cycles");
  a_store_data: assert property (@(posedge aclk) disable iff (!aresetn) // RL11
    go && cmd_op == indirect_store_instr |=> dmem.we && dmem.wdata == $past(cmd_src))
    else $error("store data wrong");
  a_code_read: assert property (@(posedge aclk) disable iff (!aresetn) // RL15
    go && cmd_op == code_memory_read_instr |=> pmem.en ##1 busy [*2] ##1 !busy)
    else $error("code read not three cycles");
  a_push_sp: assert property (@(posedge aclk) disable iff (!aresetn) // RL16
    retire && q.op == stack_put_instr |=> q.sp == $past(q.sp) - 16'h0001)
    else $error("stack pointer not decremented");
  a_wdog_pulse: assert property (@(posedge aclk) disable iff (!aresetn) // RL20
    retire && q.op == watchdog_restart_instr |=> wdt_restart ##1 !wdt_restart)
    else $error("watchdog restart pulse wrong");

endmodule : bxo_core

/* File: bxo_mem_model.sv */
// Behavioural data SRAM and code memory on the far side of the core.
// Assumes one-cycle data reads and two-cycle code reads, all on aclk.
`timescale 1ns/10ps
module bxo_mem_model import bxo_pkg::*; (
  input wire logic aclk,
  input wire bxo_dmem_req_t dmem,
  output logic [7:0] dmem_rdata,
  input wire bxo_pmem_req_t pmem,
  output logic [7:0] pmem_rdata
);
  logic [7:0] mem [256];
  logic [7:0] code_q;
  initial mem = '{default: 8'h00};
  // Read data holds for one cycle only, then flips so stale bytes never pass
  always @(posedge aclk) begin
    if (dmem.en && dmem.we) begin
      mem[dmem.addr[7:0]] <= dmem.wdata;
    end
    dmem_rdata <= (dmem.en && !dmem.we) ? mem[dmem.addr[7:0]] : ~dmem_rdata;
  end
  // Two-stage code pipe; contents follow the low address byte
  always @(posedge aclk) begin
    code_q <= pmem.en ? (pmem.addr[7:0] ^ 8'h5A) : ~code_q;
    pmem_rdata <= code_q;
  end
endmodule : bxo_mem_model

/* File: test_mcu_core_bit_transfer_ops.sv */
// Self-checking bench: register bus tasks and instruction scenarios.
// Assumes bxo_pkg, bxo_core and bxo_mem_model compiled before it.
`timescale 1ns/10ps
module test_mcu_core_bit_transfer_ops import bxo_pkg::*;;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic dbg_enable = 1'b0;
  bxo_axil_req_t req = '0;
  bxo_axil_rsp_t rsp;
  bxo_dmem_req_t dmem;
  bxo_pmem_req_t pmem;
  logic [7:0] dmem_rdata, pmem_rdata;
  logic sleep_req, wdt_restart, dbg_break;
  int fails = 0, n_compared = 0, n_slp = 0, n_wdt = 0, n_brk = 0;
  int fb [3] = '{FLAG_V, FLAG_H, FLAG_S};
  logic [31:0] rd_v;
  logic [1:0] resp_v;
  always #4 aclk = ~aclk;
  bxo_core dut_u (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .dmem(dmem), .dmem_rdata(dmem_rdata), .pmem(pmem), .pmem_rdata(pmem_rdata),
    .dbg_enable(dbg_enable), .sleep_req(sleep_req), .wdt_restart(wdt_restart),
    .dbg_break(dbg_break));
  bxo_mem_model mem_u (.aclk(aclk), .dmem(dmem), .dmem_rdata(dmem_rdata), .pmem(pmem),
    .pmem_rdata(pmem_rdata));
  // Count the one-cycle control pulses
  always @(posedge aclk) begin
    if (sleep_req === 1'b1) n_slp <= n_slp + 1;
    if (wdt_restart === 1'b1) n_wdt <= n_wdt + 1;
    if (dbg_break === 1'b1) n_brk <= n_brk + 1;
  end
  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // One clock with a bound, so a silent slave cannot hang the run
  task automatic step(inout int n);
    @(posedge aclk);
    n++;
    if (n > 100) begin
      fails++;
      end_of_test();
    end
  endtask : step
  // Ready lines stay high throughout, which keeps each handshake legal
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.awaddr <= {24'h0, a};
    req.wdata <= d;
    req.wstrb <= 4'hF;
    do step(n); while (rsp.awready !== 1'b1);
    req.awvalid <= 1'b0;
    req.wvalid <= 1'b0;
    do step(n); while (rsp.bvalid !== 1'b1);
    resp_v = rsp.bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n = 0;
    req.arvalid <= 1'b1;
    req.araddr <= {24'h0, a};
    do step(n); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do step(n); while (rsp.rvalid !== 1'b1);
    rd_v = rsp.rdata;
    resp_v = rsp.rresp;
  endtask : rd
  task automatic wreg(input int r, input logic [7:0] v);
    wr(RF_OFF + 8'(4 * r), {24'h0, v});
  endtask : wreg
  task automatic creg(input int r, input logic [7:0] e);
    rd(RF_OFF + 8'(4 * r));
    chk($sformatf("r%0d", r), {24'h0, rd_v[7:0]}, {24'h0, e});
  endtask : creg
  task automatic cflags(input logic [7:0] e);
    rd(FLAGS_OFF);
    chk("flags", rd_v, {24'h0, e});
  endtask : cflags
  // Issue a command, then poll the busy bit with a bound
  task automatic run(input int op, input int d, input int r, input int b, input int p,
                     input int m);
    int n = 0;
    wr(CTRL_OFF, (m << MODE_LSB) | (p << PTR_LSB) | (b << BIT_LSB) | (r << RR_LSB)
       | (d << RD_LSB) | op);
    do begin
      rd(STAT_OFF);
      step(n);
    end while (rd_v[BUSY_BIT] !== 1'b0);
  endtask : run
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    req.bready <= 1'b1;
    req.rready <= 1'b1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    cflags(FLAGS_RST);
    rd(SP_OFF);
    chk("sp", rd_v, {16'h0, SP_RST});
    rd(8'h14);
    chk("rresp", {30'h0, resp_v}, {30'h0, RESP_SLVERR});
    wr(STAT_OFF, 32'h0);
    chk("bresp", {30'h0, resp_v}, {30'h0, RESP_SLVERR});
    // Shifts: rotate takes carry in at the top, shift keeps bit 7, old bit 0 out to carry; then swap
    wreg(16, 8'h81);
    wr(FLAGS_OFF, 32'h01);
    chk("bresp", {30'h0, resp_v}, {30'h0, RESP_OKAY});
    run(1, 16, 0, 0, 0, 0);
    creg(16, 8'hC0);
    cflags(8'h05);
    wreg(17, 8'h81);
    wr(FLAGS_OFF, 32'h00);
    run(2, 17, 0, 0, 0, 0);
    creg(17, 8'hC0);
    cflags(8'h05);
    run(3, 16, 0, 0, 0, 0);
    creg(16, 8'h0C);
    cflags(8'h05);
    // Single-flag set and clear over a mixed background, then transfer flag moves and pair copy
    wr(FLAGS_OFF, 32'h83);
    foreach (fb[i]) begin
      run(6 + 2 * i, 0, 0, 0, 0, 0);
      cflags(8'h83 | (8'h01 << fb[i]));
      run(7 + 2 * i, 0, 0, 0, 0, 0);
      cflags(8'h83);
    end
    wreg(5, 8'h04);
    wreg(6, 8'h00);
    run(4, 0, 5, 2, 0, 0);
    cflags(8'hC3);
    run(5, 6, 0, 7, 0, 0);
    creg(6, 8'h80);
    run(4, 0, 5, 0, 0, 0);
    cflags(8'h83);
    run(12, 2, 16, 0, 0, 0);
    creg(2, 8'h0C);
    creg(3, 8'hC0);
    // Data transfers through X, Y, direct address and stack, then a code memory read through Z
    wreg(1, 8'hA5);
    wreg(4, 8'h3C);
    wreg(26, 8'h40);
    wreg(27, 8'h00);
    run(16, 0, 1, 0, 0, 1);
    chk("m40", {24'h0, mem_u.mem[8'h40]}, 32'hA5);
    creg(26, 8'h41);
    run(13, 2, 0, 0, 0, 2);
    creg(2, 8'hA5);
    creg(26, 8'h40);
    run(16, 0, 4, 0, 0, 2);
    chk("m3f", {24'h0, mem_u.mem[8'h3F]}, 32'h3C);
    run(13, 3, 0, 0, 0, 1);
    creg(3, 8'h3C);
    creg(26, 8'h40);
    wreg(28, 8'h30);
    wreg(29, 8'h00);
    wr(OPND_OFF, 32'h05);
    run(17, 0, 1, 0, 1, 0);
    chk("m35", {24'h0, mem_u.mem[8'h35]}, 32'hA5);
    run(14, 7, 0, 0, 1, 0);
    creg(7, 8'hA5);
    creg(28, 8'h30);
    wr(OPND_OFF, 32'h50);
    run(18, 0, 4, 0, 0, 0);
    chk("m50", {24'h0, mem_u.mem[8'h50]}, 32'h3C);
    run(15, 8, 0, 0, 0, 0);
    creg(8, 8'h3C);
    run(20, 0, 1, 0, 0, 0);
    chk("mff", {24'h0, mem_u.mem[8'hFF]}, 32'hA5);
    rd(SP_OFF);
    chk("sp", rd_v, 32'hFE);
    run(21, 9, 0, 0, 0, 0);
    creg(9, 8'hA5);
    wreg(30, 8'h30);
    wreg(31, 8'h00);
    run(19, 10, 0, 0, 2, 1);
    creg(10, 8'h6A);
    creg(30, 8'h31);
    cflags(8'h83);
    // Control pulses; break only counts with debugging on
    run(22, 0, 0, 0, 0, 0);
    run(23, 0, 0, 0, 0, 0);
    run(24, 0, 0, 0, 0, 0);
    dbg_enable <= 1'b1;
    run(24, 0, 0, 0, 0, 0);
    chk("sleep", n_slp, 1);
    chk("wdt", n_wdt, 1);
    chk("brk", n_brk, 1);
    end_of_test();
  end
endmodule : test_mcu_core_bit_transfer_ops
